// ===== hdl/cis_core.sv
// cpu instruction decoder, executor and event status word
`timescale 1ns/1ps
module cis_core #(
  parameter int unsigned STACK_DEPTH = 4,
  parameter logic [4:0]  DIVMOD_CYC  = 5'h14
) (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // program store, combinational read
  output logic [12:0]               prog_addr,
  input  wire logic [7:0]           prog_data,
  // data ram
  output logic [7:0]                ram_raddr,
  input  wire logic [23:0]          ram_rdata,
  output logic                      ram_we,
  output logic [7:0]                ram_waddr,
  output logic [23:0]               ram_wdata,
  // user eeprom
  output logic [6:0]                eep_addr,
  input  wire logic [7:0]           eep_rdata,
  // events
  input  wire logic [3:0]           cap_level_pin,
  input  wire logic                 run_start,
  input  wire logic [4:0]           wake_cause,
  input  wire cisp::cis_errors_type err_in,
  // status and control
  output logic [23:0]               event_status_word,
  output cisp::cis_flags_type       alu_flags,
  output logic                      slow_clock_select,
  output logic                      wdt_restart,
  output logic                      halted
);
  localparam int unsigned SP_W = $clog2(STACK_DEPTH);

  typedef struct packed {
    cisp::cis_mode_type            mode;
    logic                          halt;
    logic [12:0]                   pc;
    logic [12:0]                   start;
    logic [2:0]                    idx;
    logic [2:0]                    slen;
    logic [1:0]                    skip_left;
    logic [4:0]                    cnt;
    logic [4:0][7:0]               ib;
    logic [2:0][23:0]              acc;
    cisp::cis_flags_type           fl;
    logic [7:0]                    ptr;
    logic [STACK_DEPTH-1:0][12:0]  stk;
    logic [SP_W-1:0]               sp;
    logic                          eep_pend;
    logic [1:0]                    eep_dst;
    logic                          slow;
    logic                          wdt;
    logic                          we;
    logic [7:0]                    waddr;
    logic [23:0]                   wdata;
    logic [3:0]                    cap_s1;
    logic [3:0]                    cap_s2;
    logic [3:0]                    cap_prev;
    logic [3:0]                    rise;
    logic [3:0]                    fall;
    logic [4:0]                    cause;
    cisp::cis_errors_type          err;
    logic [23:0]                   stat;
  } cis_state_type;

  cis_state_type    q;
  cis_state_type    next_q;
  logic [23:0]      stat_now;
  logic [23:0]      rval;
  logic [4:0][7:0]  by;
  logic [7:0]       op;
  logic [1:0]       a;
  logic [1:0]       b;
  logic [23:0]      va;
  logic [23:0]      vb;
  logic [23:0]      opb;
  logic [23:0]      opl;
  logic [24:0]      sum;
  logic [24:0]      dif;
  logic [24:0]      ng;
  logic [23:0]      msk;
  logic [47:0]      quo48;
  logic [2:0]       len;
  logic [2:0]       sl;
  logic [4:0]       cyc;
  logic [12:0]      npc;
  logic [12:0]      spc;
  logic             dwr;
  logic [1:0]       dst;
  logic [23:0]      dval;
  logic             dwr2;
  logic [1:0]       dst2;
  logic [23:0]      dval2;
  logic             szu;
  logic [23:0]      szv;
  logic             cou;
  logic             cn;
  logic             on;

  // undefined opcode groups decode as one-byte no operation
  function automatic logic [2:0] oplen(input logic [7:0] o);
    logic [2:0] l;
    l = cisp::LEN_1;
    case (o[7:4])
      cisp::G_KOP:  l = cisp::LEN_4;
      cisp::G_LOG,
      cisp::G_BIT,
      cisp::G_BRA,
      cisp::G_SKIP: l = cisp::LEN_2;
      cisp::G_LOGK: l = cisp::LEN_5;
      cisp::G_GOTO: l = cisp::LEN_3;
      cisp::G_CALL: if (o[3:0] == cisp::C_ALW) l = cisp::LEN_3;
      cisp::G_MISC: begin
        if (o[3:0] == cisp::M_WDT || o[3:0] == cisp::M_SLOW || o[3:0] == cisp::M_SETP)
          l = cisp::LEN_2;
      end
      default: l = cisp::LEN_1;
    endcase
    return l;
  endfunction

  function automatic logic cond_ok(input logic [3:0] c, input cisp::cis_flags_type f);
    logic r;
    case (c)
      cisp::C_ALW: r = 1'b1;
      cisp::C_CC:  r = !f.carry;
      cisp::C_CS:  r = f.carry;
      cisp::C_EQ:  r = !f.nz;
      cisp::C_NE:  r = f.nz;
      cisp::C_NEG: r = f.sign;
      cisp::C_OC:  r = !f.ovf;
      cisp::C_OS:  r = f.ovf;
      cisp::C_POS: r = !f.sign;
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic [23:0] rd(input logic [1:0] i, input logic [2:0][23:0] ac,
                                     input logic [23:0] r);
    return (i == cisp::ACC_R) ? r : ac[i];
  endfunction

  // bit 12 stays zero; whole word assembled for one read
  assign stat_now = {q.cap_s2, q.cause, q.err.supply_low, q.err.conv_err, 1'b0,
                     q.err.cap_err, q.err.gauge_err, q.err.conv_timeout,
                     q.err.ext_start, q.rise, q.fall};

  // pending ram write is bypassed so back-to-back ops see fresh data
  assign rval = (q.ptr == cisp::STATUS_ADDR) ? q.stat :
                (q.we && q.waddr == q.ptr) ? q.wdata : ram_rdata;

  always_comb begin
    next_q = q;
    next_q.wdt = 1'b0;
    next_q.we = 1'b0;
    by = q.ib;
    by[q.idx] = prog_data;
    op = by[0];
    a = op[3:2];
    b = op[1:0];
    va = rd(a, q.acc, rval);
    vb = rd(b, q.acc, rval);
    opb = (op[7:4] == cisp::G_KOP) ? {by[1], by[2], by[3]} : vb;
    opl = (op[7:4] == cisp::G_LOGK) ? {by[2], by[3], by[4]} : vb;
    sum = {1'b0, va} + {1'b0, opb};
    dif = {1'b0, opb} - {1'b0, va};
    ng = 25'h0 - {1'b0, va};
    msk = 24'h1 << by[1][4:0];
    quo48 = (vb == 24'h0) ? 48'hFFFFFFFFFFFF :
            48'($signed({va, 24'h0}) / $signed({{24{vb[23]}}, vb}));
    len = oplen(op);
    sl = (q.idx == 3'h0) ? oplen(prog_data) : q.slen;
    spc = (q.idx == 3'h0) ? q.pc : q.start;
    npc = 13'(q.pc + 13'h1);
    cyc = {2'h0, len};
    dwr = 1'b0;
    dst = a;
    dval = 24'h0;
    dwr2 = 1'b0;
    dst2 = b;
    dval2 = 24'h0;
    szu = 1'b0;
    szv = 24'h0;
    cou = 1'b0;
    cn = 1'b0;
    on = 1'b0;

    // pin levels pass two flops; edges taken after the second
    next_q.cap_s1 = cap_level_pin;
    next_q.cap_s2 = q.cap_s1;
    next_q.cap_prev = q.cap_s2;
    // new run clears sticky flags, but a same-cycle event still wins
    next_q.rise = (run_start ? 4'h0 : q.rise) | (q.cap_s2 & ~q.cap_prev);
    next_q.fall = (run_start ? 4'h0 : q.fall) | (~q.cap_s2 & q.cap_prev);
    next_q.err = (run_start ? '0 : q.err) | err_in;
    if (run_start)
      next_q.cause = wake_cause;
    next_q.stat = stat_now;

    case (q.mode)
      cisp::MODE_HALT: begin
        if (run_start) begin
          next_q.mode = cisp::MODE_RUN;
          next_q.pc = cisp::RESET_VEC;
          next_q.idx = 3'h0;
        end
      end
      cisp::MODE_WAIT: begin
        next_q.cnt = 5'(q.cnt - 5'h1);
        if (q.cnt == 5'h1) begin
          next_q.mode = cisp::MODE_RUN;
          if (q.eep_pend) begin
            next_q.eep_pend = 1'b0;
            next_q.sp = SP_W'(q.sp - 1'b1);
            dwr = 1'b1;
            dst = q.eep_dst;
            dval = {16'h0, eep_rdata};
          end
        end
      end
      cisp::MODE_SKIP: begin
        next_q.pc = npc;
        next_q.slen = sl;
        if (q.idx == 3'(sl - 3'h1)) begin
          next_q.idx = 3'h0;
          next_q.skip_left = 2'(q.skip_left - 2'h1);
          if (q.skip_left == 2'h1)
            next_q.mode = cisp::MODE_RUN;
        end else begin
          next_q.idx = 3'(q.idx + 3'h1);
        end
      end
      cisp::MODE_RUN: begin
        if (q.idx != 3'(len - 3'h1)) begin
          // bytes arrive one per cycle, so byte count sets the floor on cycles
          next_q.ib = by;
          next_q.idx = 3'(q.idx + 3'h1);
          next_q.pc = npc;
          next_q.start = spc;
        end else begin
          next_q.idx = 3'h0;
          case (op[7:4])
            cisp::G_ADD: begin
              dwr = 1'b1;
              dval = sum[23:0];
              cou = 1'b1;
              cn = sum[24];
              on = (va[23] == opb[23]) && (sum[23] != va[23]);
            end
            cisp::G_CMP: begin
              szu = 1'b1;
              szv = dif[23:0];
              cou = 1'b1;
              cn = dif[24];
              on = (opb[23] != va[23]) && (dif[23] != opb[23]);
            end
            cisp::G_MOVE: begin
              dwr = 1'b1;
              dval = vb;
            end
            cisp::G_KOP: begin
              cyc = cisp::CYC_4;
              if (b == cisp::K_ADD) begin
                dwr = 1'b1;
                dval = sum[23:0];
                cou = 1'b1;
                cn = sum[24];
                on = (va[23] == opb[23]) && (sum[23] != va[23]);
              end else if (b == cisp::K_CMP) begin
                szu = 1'b1;
                szv = dif[23:0];
                cou = 1'b1;
                cn = dif[24];
                on = (opb[23] != va[23]) && (dif[23] != opb[23]);
              end else if (b == cisp::K_MOVE) begin
                dwr = 1'b1;
                dval = opb;
              end
            end
            cisp::G_ONE: begin
              if (b == cisp::ONE_CLR) begin
                dwr = 1'b1;
              end else if (b == cisp::ONE_FLAG) begin
                szu = 1'b1;
                szv = va;
              end else if (b == cisp::ONE_EEP) begin
                cyc = cisp::CYC_6;
                next_q.stk[q.sp] = npc;
                next_q.sp = SP_W'(q.sp + 1'b1);
                next_q.eep_pend = 1'b1;
                next_q.eep_dst = a;
              end
            end
            cisp::G_LOG,
            cisp::G_LOGK: begin
              cyc = (op[7:4] == cisp::G_LOGK) ? cisp::CYC_6 : cisp::CYC_3;
              case ((op[7:4] == cisp::G_LOGK) ? {6'h0, b} : by[1])
                cisp::L_AND: begin
                  dwr = 1'b1;
                  dval = va & opl;
                end
                cisp::L_XOR: begin
                  dwr = 1'b1;
                  dval = va ^ opl;
                end
                cisp::L_XNOR: begin
                  dwr = 1'b1;
                  dval = ~(va ^ opl);
                end
                cisp::L_DIV: begin
                  if (op[7:4] == cisp::G_LOG) begin
                    cyc = cisp::CYC_DIV;
                    dwr = 1'b1;
                    dval = quo48[23:0];
                  end
                end
                cisp::L_DIVMOD: begin
                  if (op[7:4] == cisp::G_LOG && vb != 24'h0) begin
                    cyc = DIVMOD_CYC;
                    dwr = 1'b1;
                    dval = 24'($signed(va) / $signed(vb));
                    dwr2 = 1'b1;
                    dval2 = 24'($signed(va) % $signed(vb));
                  end
                end
                default: cyc = cisp::CYC_3;
              endcase
            end
            cisp::G_BIT: begin
              dwr = 1'b1;
              case (by[1][7:5])
                cisp::B_ABS: begin
                  dval = va[23] ? ng[23:0] : va;
                  cou = 1'b1;
                  cn = va[23] & ng[24];
                  on = va[23] & ng[23];
                end
                cisp::B_CLR: dval = va & ~msk;
                cisp::B_INV: dval = va ^ msk;
                cisp::B_SET: dval = va | msk;
                default: dwr = 1'b0;
              endcase
            end
            cisp::G_MISC: begin
              case (op[3:0])
                cisp::M_CLRCO: begin
                  next_q.fl.carry = 1'b0;
                  next_q.fl.ovf = 1'b0;
                end
                cisp::M_WDT: next_q.wdt = 1'b1;
                cisp::M_SLOW: begin
                  cyc = cisp::CYC_3;
                  next_q.slow = by[1][0];
                end
                cisp::M_STOP: next_q.mode = cisp::MODE_HALT;
                cisp::M_RET: begin
                  cyc = cisp::CYC_3;
                  npc = q.stk[SP_W'(q.sp - 1'b1)];
                  next_q.sp = SP_W'(q.sp - 1'b1);
                end
                cisp::M_INCP: next_q.ptr = 8'(q.ptr + 8'h1);
                cisp::M_DECP: next_q.ptr = 8'(q.ptr - 8'h1);
                cisp::M_SETP: next_q.ptr = by[1];
                default: cyc = cisp::CYC_1;
              endcase
            end
            cisp::G_GOTO: begin
              cyc = cisp::CYC_4;
              if (cond_ok(op[3:0], q.fl))
                npc = {by[1][4:0], by[2]};
            end
            cisp::G_BRA: begin
              cyc = cisp::CYC_3;
              if (cond_ok(op[3:0], q.fl))
                npc = 13'(spc + {{5{by[1][7]}}, by[1]});
            end
            cisp::G_SKIP: begin
              cyc = cisp::CYC_2;
              if (cond_ok(op[3:0], q.fl) && by[1][5:4] != 2'h0) begin
                next_q.mode = cisp::MODE_SKIP;
                next_q.skip_left = by[1][5:4];
              end
            end
            cisp::G_CALL: begin
              if (op[3:0] == cisp::C_ALW) begin
                cyc = cisp::CYC_4;
                next_q.stk[q.sp] = npc;
                next_q.sp = SP_W'(q.sp + 1'b1);
                npc = {by[1][4:0], by[2]};
              end
            end
            default: cyc = cisp::CYC_1;
          endcase
          next_q.pc = npc;
          if (cyc > {2'h0, len} && next_q.mode == cisp::MODE_RUN) begin
            next_q.mode = cisp::MODE_WAIT;
            next_q.cnt = 5'(cyc - {2'h0, len});
          end
        end
      end
      default: next_q.mode = cisp::MODE_HALT;
    endcase

    // write-back; first operand wins if both name the same accumulator
    for (int i = 0; i < 3; i++) begin
      if (dwr2 && dst2 == 2'(i))
        next_q.acc[i] = dval2;
      if (dwr && dst == 2'(i))
        next_q.acc[i] = dval;
    end
    if ((dwr && dst == cisp::ACC_R) || (dwr2 && dst2 == cisp::ACC_R)) begin
      next_q.we = 1'b1;
      next_q.waddr = q.ptr;
      next_q.wdata = (dwr && dst == cisp::ACC_R) ? dval : dval2;
    end
    if (dwr) begin
      szu = 1'b1;
      szv = dval;
    end
    if (szu) begin
      next_q.fl.sign = szv[23];
      next_q.fl.nz = |szv;
    end
    if (cou) begin
      next_q.fl.carry = cn;
      next_q.fl.ovf = on;
    end
    next_q.halt = (next_q.mode == cisp::MODE_HALT);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      q <= '0;
      q.pc <= cisp::RESET_VEC;
      q.mode <= cisp::MODE_HALT;
      q.halt <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign prog_addr = q.pc;
  assign ram_raddr = q.ptr;
  assign ram_we = q.we;
  assign ram_waddr = q.waddr;
  assign ram_wdata = q.wdata;
  assign eep_addr = q.ptr[6:0];
  assign event_status_word = q.stat;
  assign alu_flags = q.fl;
  assign slow_clock_select = q.slow;
  assign wdt_restart = q.wdt;
  assign halted = q.halt;
endmodule

// ===== hdl/cisp.sv
// shared constants and types for the cpu decoder and status word
package cisp;
  // status word lives at this ram location
  localparam logic [7:0]  STATUS_ADDR = 8'hF6;
  localparam logic [12:0] RESET_VEC   = 13'h0030;
  localparam logic [1:0]  ACC_R       = 2'h3;
  // opcode groups, upper nibble of the first byte
  localparam logic [3:0] G_ADD  = 4'h0;
  localparam logic [3:0] G_CMP  = 4'h1;
  localparam logic [3:0] G_MOVE = 4'h2;
  localparam logic [3:0] G_KOP  = 4'h3;
  localparam logic [3:0] G_ONE  = 4'h4;
  localparam logic [3:0] G_LOG  = 4'h5;
  localparam logic [3:0] G_BIT  = 4'h6;
  localparam logic [3:0] G_LOGK = 4'h7;
  localparam logic [3:0] G_MISC = 4'h8;
  localparam logic [3:0] G_GOTO = 4'hA;
  localparam logic [3:0] G_BRA  = 4'hB;
  localparam logic [3:0] G_SKIP = 4'hC;
  localparam logic [3:0] G_CALL = 4'hD;
  // sub operations
  localparam logic [1:0] K_ADD = 2'h0;
  localparam logic [1:0] K_CMP = 2'h1;
  localparam logic [1:0] K_MOVE = 2'h2;
  localparam logic [1:0] ONE_CLR = 2'h0;
  localparam logic [1:0] ONE_FLAG = 2'h1;
  localparam logic [1:0] ONE_EEP = 2'h2;
  localparam logic [7:0] L_AND = 8'h00;
  localparam logic [7:0] L_XOR = 8'h01;
  localparam logic [7:0] L_XNOR = 8'h02;
  localparam logic [7:0] L_DIV = 8'h03;
  localparam logic [7:0] L_DIVMOD = 8'h04;
  localparam logic [2:0] B_ABS = 3'h0;
  localparam logic [2:0] B_CLR = 3'h1;
  localparam logic [2:0] B_INV = 3'h2;
  localparam logic [2:0] B_SET = 3'h3;
  localparam logic [3:0] M_CLRCO = 4'h1;
  localparam logic [3:0] M_WDT = 4'h2;
  localparam logic [3:0] M_SLOW = 4'h3;
  localparam logic [3:0] M_STOP = 4'h4;
  localparam logic [3:0] M_RET = 4'h5;
  localparam logic [3:0] M_INCP = 4'h6;
  localparam logic [3:0] M_DECP = 4'h7;
  localparam logic [3:0] M_SETP = 4'h8;
  // branch conditions
  localparam logic [3:0] C_ALW = 4'h0;
  localparam logic [3:0] C_CC = 4'h1;
  localparam logic [3:0] C_CS = 4'h2;
  localparam logic [3:0] C_EQ = 4'h3;
  localparam logic [3:0] C_NE = 4'h4;
  localparam logic [3:0] C_NEG = 4'h5;
  localparam logic [3:0] C_OC = 4'h6;
  localparam logic [3:0] C_OS = 4'h7;
  localparam logic [3:0] C_POS = 4'h8;
  // lengths in bytes and cycles
  localparam logic [2:0] LEN_1 = 3'h1;
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;
  localparam logic [2:0] LEN_5 = 3'h5;
  localparam logic [4:0] CYC_1 = 5'h01;
  localparam logic [4:0] CYC_2 = 5'h02;
  localparam logic [4:0] CYC_3 = 5'h03;
  localparam logic [4:0] CYC_4 = 5'h04;
  localparam logic [4:0] CYC_6 = 5'h06;
  localparam logic [4:0] CYC_DIV = 5'h14;
  typedef struct packed {
    logic carry;
    logic ovf;
    logic sign;
    logic nz;
  } cis_flags_type;
  typedef struct packed {
    logic supply_low;
    logic conv_err;
    logic cap_err;
    logic gauge_err;
    logic conv_timeout;
    logic ext_start;
  } cis_errors_type;
  typedef enum logic [1:0] {MODE_HALT, MODE_RUN, MODE_WAIT, MODE_SKIP} cis_mode_type;
endpackage

// ===== sim/cis_monitor.sv
// checker for the cpu decoder status word and flags
`timescale 1ns/1ps
module cis_monitor (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 nrst,
  // events
  input wire logic [3:0]           cap_level_pin,
  input wire logic                 run_start,
  input wire logic [4:0]           wake_cause,
  input wire cisp::cis_errors_type err_in,
  // outputs watched
  input wire logic [23:0]          event_status_word,
  input wire cisp::cis_flags_type  alu_flags,
  input wire logic                 ram_we,
  input wire logic [23:0]          ram_wdata,
  input wire logic                 slow_clock_select,
  input wire logic                 wdt_restart,
  input wire logic                 halted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_reserved_zero: assert property (event_status_word[12] == 1'b0)
    else $error("reserved status bit set");
  chk_rise_edge: assert property ($rose(cap_level_pin[0]) |-> ##4 event_status_word[4])
    else $error("rising edge flag missing");
  chk_fall_edge: assert property ($fell(cap_level_pin[0]) |-> ##4 event_status_word[0])
    else $error("falling edge flag missing");
  // sync chain plus status register gives the level three edges late
  chk_level_follow: assert property ($stable(cap_level_pin) [*5] |->
    event_status_word[23:20] == cap_level_pin) else $error("port level wrong");
  chk_err_sticky: assert property ((|err_in) |-> ##2
    (({event_status_word[14:13], event_status_word[11:8]} & $past(err_in, 2))
     == $past(err_in, 2))) else $error("error flag missing");
  chk_cause_latch: assert property (run_start |-> ##2
    event_status_word[19:15] == $past(wake_cause, 2)) else $error("wake cause wrong");
  // flags and the write request leave the same edge, so no past value here
  chk_flags_write: assert property (ram_we |->
    alu_flags.sign == ram_wdata[23] && alu_flags.nz == (ram_wdata != 24'h000000))
    else $error("flags disagree with written word");
  chk_wdt_pulse: assert property (wdt_restart |=> !wdt_restart)
    else $error("watchdog restart too long");
  chk_slow_run: assert property ($changed(slow_clock_select) |-> !$past(halted))
    else $error("clock select moved while halted");
endmodule
bind cis_core cis_monitor mon_u (.clk(clk), .nrst(nrst), .cap_level_pin(cap_level_pin),
  .run_start(run_start), .wake_cause(wake_cause), .err_in(err_in),
  .event_status_word(event_status_word), .alu_flags(alu_flags), .ram_we(ram_we),
  .ram_wdata(ram_wdata), .slow_clock_select(slow_clock_select), .wdt_restart(wdt_restart),
  .halted(halted));

// ===== sim/tb.sv
// testbench for the cpu decoder and status word
`timescale 1ns/1ps
module tb;
  logic                 clk, nrst, run_start, ram_we, slow_clock_select, wdt_restart, halted;
  logic [12:0]          prog_addr;
  logic [7:0]           prog_data, ram_raddr, ram_waddr, eep_rdata;
  logic [6:0]           eep_addr;
  logic [4:0]           wake_cause;
  logic [3:0]           cap_level_pin;
  logic [23:0]          ram_rdata, ram_wdata, event_status_word;
  cisp::cis_errors_type err_in;
  cisp::cis_flags_type  alu_flags;
  logic [7:0]           rom [8192];
  logic [23:0]          ram [256];
  logic [23:0]          wq [$];
  int                   bad_count, n_checks, wdt_n, base, n;
  // code, length and cycles of single instructions, measured against a bare stop
  localparam logic [39:0] TC [14] = '{40'h0100000000, 40'h3000000100, 40'h6000000000,
    40'h5100000000, 40'h7200000F00, 40'h6060000000, 40'h4000000000, 40'h8300000000,
    40'h8100000000, 40'h3100000200, 40'h5103000000, 40'h4200000000, 40'h4100000000,
    40'h8200000000};
  localparam int TL [14] = '{1, 4, 2, 2, 5, 2, 1, 2, 1, 4, 2, 1, 1, 2};
  localparam int TY [14] = '{1, 4, 2, 3, 6, 2, 1, 3, 1, 4, 20, 6, 1, 2};
  assign prog_data = rom[prog_addr];
  assign ram_rdata = ram[ram_raddr];
  assign eep_rdata = {1'b0, eep_addr} ^ 8'h5A;
  always @(posedge clk) begin
    if (ram_we) begin
      ram[ram_waddr] <= ram_wdata;
      wq.push_back(ram_wdata);
    end
    if (wdt_restart) wdt_n++;
  end
  cis_core dut_u (.clk(clk), .nrst(nrst), .prog_addr(prog_addr), .prog_data(prog_data),
    .ram_raddr(ram_raddr), .ram_rdata(ram_rdata), .ram_we(ram_we), .ram_waddr(ram_waddr),
    .ram_wdata(ram_wdata), .eep_addr(eep_addr), .eep_rdata(eep_rdata),
    .cap_level_pin(cap_level_pin), .run_start(run_start), .wake_cause(wake_cause),
    .err_in(err_in), .event_status_word(event_status_word), .alu_flags(alu_flags),
    .slow_clock_select(slow_clock_select), .wdt_restart(wdt_restart), .halted(halted));
  task chk(input logic [23:0] got, input logic [23:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task put(input logic [12:0] a, input logic [39:0] c, input int l);
    for (int i = 0; i < l; i++) rom[a + i] = c[39 - 8 * i -: 8];
  endtask
  // the optional event burst lands while the first instruction is still busy
  task run(input logic ev, output int k);
    k = 0;
    wq.delete();
    run_start = 1'b1;
    @(negedge clk);
    run_start = 1'b0;
    while (halted !== 1'b1 && k < 1000) begin
      @(negedge clk);
      k++;
      if (ev && k == 2) begin
        err_in = 6'b100100;
        cap_level_pin = 4'h1;
      end
      if (ev && k == 3) err_in = 6'b000000;
    end
    if (k >= 1000) bad_count++;
  endtask
  task t_reset;
    chk(24'({halted, slow_clock_select, wdt_restart, alu_flags}), 24'h000040);
    chk(24'(prog_addr), 24'h000030);
    chk(event_status_word, 24'h000000);
  endtask
  task t_cycles;
    put(13'h030, 40'h8400000000, 1);
    run(1'b0, base);
    for (int k = 0; k < 14; k++) begin
      put(13'h030, TC[k], TL[k]);
      put(13'h030 + 13'(TL[k]), 40'h8400000000, 1);
      run(1'b0, n);
      chk(24'(n - base), 24'(TY[k]));
    end
  endtask
  task t_arith;
    put(13'h030, 40'h3200000536, 5);
    put(13'h035, 40'hFFFFFD012C, 5);
    put(13'h03A, 40'h60572C1481, 5);
    put(13'h03F, 40'h8803422C84, 5);
    run(1'b0, n);
    chk(24'(wq.size()), 24'h000003);
    chk(wq[0], 24'h000002);
    chk(wq[1], 24'h800002);
    chk(ram[3], 24'h000059);
    chk(24'(alu_flags), 24'h000001);
  endtask
  task t_jump;
    put(13'h030, 40'h32000009A0, 5);
    put(13'h035, 40'h1F40000000, 2);
    put(13'h1F40, 40'hB080000000, 2);
    put(13'h1EC0, 40'hC020320000, 5);
    put(13'h1EC5, 40'h072C2C8400, 4);
    run(1'b0, n);
    chk(24'(wq.size()), 24'h000001);
    chk(wq[0], 24'h000009);
  endtask
  task t_status;
    wdt_n = 0;
    wake_cause = 5'b10100;
    put(13'h030, 40'h5103830182, 5);
    put(13'h035, 40'h0088F62388, 5);
    put(13'h03A, 40'h002C840000, 3);
    run(1'b1, n);
    chk(wq[0], 24'h1A4410);
    chk(24'(slow_clock_select), 24'h000001);
    chk(24'(wdt_n), 24'h000001);
    cap_level_pin = 4'h0;
    repeat (8) @(negedge clk);
    chk(event_status_word, 24'h0A4411);
  endtask
  // call into a divmod routine; a conditional call byte must fall through as a nop
  task t_call;
    put(13'h030, 40'h3200001136, 5);
    put(13'h035, 40'hFFFFFBD000, 5);
    put(13'h03A, 40'h402C2D4CD1, 5);
    put(13'h03F, 40'h8400000000, 1);
    put(13'h040, 40'h5104850000, 3);
    run(1'b0, n);
    chk(24'(wq.size()), 24'h000003);
    chk(wq[0], 24'hFFFFFD);
    chk(wq[1], 24'h000002);
    chk(wq[2], 24'h000000);
    chk(24'(alu_flags), 24'h000000);
  endtask
  task test_done;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    run_start = 1'b0;
    wake_cause = 5'h00;
    err_in = 6'b000000;
    cap_level_pin = 4'h0;
    bad_count = 0;
    n_checks = 0;
    wdt_n = 0;
    foreach (rom[i]) rom[i] = 8'h80;
    foreach (ram[i]) ram[i] = 24'h000000;
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    t_reset;
    t_cycles;
    t_arith;
    t_jump;
    t_status;
    t_call;
    test_done;
  end
  // whole run needs well under two thousand cycles
  initial begin
    #40000;
    bad_count++;
    test_done;
  end
endmodule
